// >>> logic/sp2c_cfg_if.sv
// register fields handed from the register bank to the frame policy
`timescale 1ns/10ps
interface sp2c_cfg_if;
	logic [sp2c_pkg::VID_W-1:0]  vlan_identifier;
	logic [sp2c_pkg::PRI_W-1:0]  pri;
	logic                        cfi;
	logic                        ingress_filter;
	logic                        discard_non_pvid;
	logic                        pri_ceiling;
	logic                        rx_en;
	logic                        learn_dis;
	logic                        rx_mirror;
	logic [sp2c_pkg::MEMB_W-1:0] membership;
	logic [1:0]                  limit_mode;
	logic                        count_ifg;
	logic                        count_pre;
	modport regs (output vlan_identifier, pri, cfi, ingress_filter, discard_non_pvid, pri_ceiling, rx_en,
		learn_dis, rx_mirror, membership, limit_mode, count_ifg, count_pre);
	modport policy (input vlan_identifier, pri, cfi, ingress_filter, discard_non_pvid, pri_ceiling, rx_en,
		learn_dis, rx_mirror, membership, limit_mode, count_ifg, count_pre);
endinterface

// >>> logic/sp2c_frame_policy.sv
// per-frame decision from the port two control fields
`timescale 1ns/10ps
module sp2c_frame_policy #(
	parameter int LEN_W    = 11,
	parameter int PORT_BIT = 1
) (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	sp2c_cfg_if.policy                           cfg,
	input  wire logic                            tag_insert_en,
	input  wire logic                            rx_valid,
	input  wire logic                            rx_tagged,
	input  wire logic [sp2c_pkg::VID_W-1:0]      rx_vid,
	input  wire logic [sp2c_pkg::PRI_W-1:0]      rx_pri,
	input  wire logic [sp2c_pkg::MEMB_W-1:0]     rx_vlan_members,
	input  wire logic [sp2c_pkg::MEMB_W-1:0]     rx_dest,
	input  wire logic                            rx_bcast,
	input  wire logic                            rx_mcast,
	input  wire logic                            rx_flood_ucast,
	input  wire logic [LEN_W-1:0]                rx_len,
	output logic                                 dec_valid,
	output logic                                 dec_drop,
	output logic [sp2c_pkg::VID_W-1:0]           dec_vid,
	output logic [sp2c_pkg::PRI_W-1:0]           dec_pri,
	output logic [sp2c_pkg::MEMB_W-1:0]          dec_dest,
	output logic                                 dec_learn,
	output logic                                 dec_monitor,
	output logic                                 dec_rate_counted,
	output logic [LEN_W:0]                       dec_rate_bytes,
	output logic                                 dec_insert_tag,
	output logic [sp2c_pkg::REG_W-1:0]           dec_tag
);
	typedef struct packed {
		logic                        valid;
		logic                        drop;
		logic [sp2c_pkg::VID_W-1:0]  vlan_identifier;
		logic [sp2c_pkg::PRI_W-1:0]  pri;
		logic [sp2c_pkg::MEMB_W-1:0] dest;
		logic                        learn;
		logic                        monitor;
		logic                        counted;
		logic [LEN_W:0]              bytes;
		logic                        insert;
		logic [sp2c_pkg::REG_W-1:0]  tag;
	} sp2c_pol_s;

	sp2c_pol_s s_r;
	sp2c_pol_s s_nxt;

	if (LEN_W < 4 || LEN_W > 15 || PORT_BIT < 0 || PORT_BIT >= sp2c_pkg::MEMB_W) begin : g_chk
		$error("sp2c_frame_policy: unsupported LEN_W or PORT_BIT");
	end

	always_comb begin
		logic                       untagged;
		logic                       member_miss;
		logic                       vid_miss;
		logic [sp2c_pkg::VID_W-1:0] eff_vid;
		untagged    = !rx_tagged || (rx_vid == '0);
		eff_vid     = untagged ? cfg.vlan_identifier : rx_vid;
		member_miss = cfg.ingress_filter && !rx_vlan_members[PORT_BIT];
		vid_miss    = cfg.discard_non_pvid && (eff_vid != cfg.vlan_identifier);
		s_nxt       = s_r;
		s_nxt.valid = rx_valid;
		if (rx_valid) begin
			s_nxt.drop = !cfg.rx_en || member_miss || vid_miss;
			s_nxt.vlan_identifier  = eff_vid;
			s_nxt.pri  = rx_pri;
			if (cfg.pri_ceiling && (rx_pri > cfg.pri)) begin
				s_nxt.pri = cfg.pri;
			end
			s_nxt.dest    = rx_dest & cfg.membership;
			s_nxt.learn   = !cfg.learn_dis && cfg.rx_en && !member_miss && !vid_miss;
			s_nxt.monitor = cfg.rx_mirror;
			case (sp2c_pkg::sp2c_lim_e'(cfg.limit_mode))
				sp2c_pkg::LIM_ALL: s_nxt.counted = 1'b1;
				sp2c_pkg::LIM_BMF: s_nxt.counted = rx_bcast || rx_mcast || rx_flood_ucast;
				sp2c_pkg::LIM_BM:  s_nxt.counted = rx_bcast || rx_mcast;
				sp2c_pkg::LIM_B:   s_nxt.counted = rx_bcast;
				default:           s_nxt.counted = 1'b1;
			endcase
			s_nxt.bytes = {1'b0, rx_len}
				+ (cfg.count_ifg ? (LEN_W+1)'(sp2c_pkg::IFG_BYTES) : '0)
				+ (cfg.count_pre ? (LEN_W+1)'(sp2c_pkg::PRE_BYTES) : '0);
			// only untagged frames gain a tag; tagged ones pass unchanged
			s_nxt.insert = tag_insert_en && !rx_tagged;
			s_nxt.tag    = {cfg.pri, cfg.cfi, cfg.vlan_identifier};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dec_valid        = s_r.valid;
	assign dec_drop         = s_r.drop;
	assign dec_vid          = s_r.vlan_identifier;
	assign dec_pri          = s_r.pri;
	assign dec_dest         = s_r.dest;
	assign dec_learn        = s_r.learn;
	assign dec_monitor      = s_r.monitor;
	assign dec_rate_counted = s_r.counted;
	assign dec_rate_bytes   = s_r.bytes;
	assign dec_insert_tag   = s_r.insert;
	assign dec_tag          = s_r.tag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_member_drop: assert property (rx_valid && cfg.ingress_filter
		&& !rx_vlan_members[PORT_BIT] |=> dec_valid && dec_drop)
		else $error("membership miss not dropped");
	chk_pvid_drop: assert property (rx_valid && rx_tagged && rx_vid != '0
		&& cfg.discard_non_pvid && rx_vid != cfg.vlan_identifier |=> dec_drop)
		else $error("non default vid kept");
	chk_rx_disable: assert property (rx_valid && !cfg.rx_en
		|=> dec_valid && dec_drop && !dec_learn)
		else $error("frame accepted while receive disabled");
	chk_pri_ceiling: assert property (rx_valid && cfg.pri_ceiling && rx_pri > cfg.pri
		|=> dec_pri == $past(cfg.pri))
		else $error("priority not capped");
	chk_untag_vid: assert property (rx_valid && !rx_tagged
		|=> dec_vid == $past(cfg.vlan_identifier))
		else $error("untagged frame not given default vid");
	chk_bcast_only: assert property (rx_valid && cfg.limit_mode == sp2c_pkg::LIM_B
		|=> dec_rate_counted == $past(rx_bcast))
		else $error("limit mode broadcast wrong");
	chk_count_bytes: assert property (rx_valid && cfg.count_ifg && cfg.count_pre
		|=> dec_rate_bytes == $past(rx_len) + sp2c_pkg::IFG_BYTES + sp2c_pkg::PRE_BYTES)
		else $error("gap and preamble bytes wrong");
	chk_tag_insert: assert property (rx_valid && rx_tagged
		|=> !dec_insert_tag)
		else $error("tag inserted into tagged frame");
	cov_drop: cover property (dec_valid && dec_drop);
	cov_ceiling: cover property (rx_valid && cfg.pri_ceiling && rx_pri > cfg.pri);
endmodule

// >>> logic/sp2c_pkg.sv
// constants and types of the port two control register set
package sp2c_pkg;
	localparam int          ADDR_W   = 16;
	localparam int          DATA_W   = 32;
	localparam int          REG_W    = 16;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_VFM  = 16'h0522;
	localparam logic [15:0] IDX_TAG  = 16'h0524;
	localparam logic [15:0] IDX_RATE = 16'h0526;
	localparam logic [15:0] ADDR_VFM = {IDX_VFM[13:0], 2'b00};
	localparam logic [15:0] ADDR_TAG = {IDX_TAG[13:0], 2'b00};
	localparam logic [15:0] ADDR_RATE = {IDX_RATE[13:0], 2'b00};
	// control register 2 fields
	localparam int          B_IVF    = 14;
	localparam int          B_DNP    = 13;
	localparam int          B_FFC    = 12;
	localparam int          B_BPE    = 11;
	localparam int          B_TXE    = 10;
	localparam int          B_RXE    = 9;
	localparam int          B_LDIS   = 8;
	localparam int          B_SNIF   = 7;
	localparam int          B_RXM    = 6;
	localparam int          B_TXM    = 5;
	localparam int          B_UPC    = 3;
	localparam int          MEMB_W   = 3;
	localparam logic [15:0] VFM_WMASK = 16'h7FEF;
	localparam logic [15:0] VFM_RST  = 16'h0607;
	// default tag fields
	localparam int          PRI_LSB  = 13;
	localparam int          PRI_W    = 3;
	localparam int          B_CFI    = 12;
	localparam int          VID_W    = 12;
	localparam logic [15:0] TAG_WMASK = 16'hFFFF;
	localparam logic [15:0] TAG_RST  = 16'h0001;
	// rate counting fields
	localparam int          LIM_LSB  = 2;
	localparam int          B_CIFG   = 1;
	localparam int          B_CPRE   = 0;
	localparam logic [15:0] RATE_WMASK = 16'h000F;
	localparam logic [15:0] RATE_RST = 16'h0000;
	localparam int          IFG_BYTES = 12;
	localparam int          PRE_BYTES = 8;
	// membership bit of each port
	localparam int          P1_BIT   = 0;
	localparam int          P2_BIT   = 1;
	localparam int          HOST_BIT = 2;
	typedef enum logic [1:0] {
		LIM_ALL = 2'b00,
		LIM_BMF = 2'b01,
		LIM_BM  = 2'b10,
		LIM_B   = 2'b11
	} sp2c_lim_e;
endpackage

// >>> logic/sp2c_regs.sv
// port two control register bank on apb with its per-frame policy
`timescale 1ns/10ps
module sp2c_regs #(
	parameter int LEN_W = 11
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [sp2c_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [sp2c_pkg::DATA_W-1:0]     pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic [sp2c_pkg::DATA_W-1:0]          prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            an_flow_ctrl,
	input  wire logic                            egress_tag_insert_en,
	output logic                                 flow_ctrl_en,
	output logic                                 backpressure_en,
	output logic                                 tx_enable,
	output logic                                 rx_enable,
	output logic                                 learn_enable,
	output logic                                 sniffer_port,
	output logic                                 rx_mirror,
	output logic                                 tx_mirror,
	input  wire logic                            rx_valid,
	input  wire logic                            rx_tagged,
	input  wire logic [sp2c_pkg::VID_W-1:0]      rx_vid,
	input  wire logic [sp2c_pkg::PRI_W-1:0]      rx_pri,
	input  wire logic [sp2c_pkg::MEMB_W-1:0]     rx_vlan_members,
	input  wire logic [sp2c_pkg::MEMB_W-1:0]     rx_dest,
	input  wire logic                            rx_bcast,
	input  wire logic                            rx_mcast,
	input  wire logic                            rx_flood_ucast,
	input  wire logic [LEN_W-1:0]                rx_len,
	output logic                                 dec_valid,
	output logic                                 dec_drop,
	output logic [sp2c_pkg::VID_W-1:0]           dec_vid,
	output logic [sp2c_pkg::PRI_W-1:0]           dec_pri,
	output logic [sp2c_pkg::MEMB_W-1:0]          dec_dest,
	output logic                                 dec_learn,
	output logic                                 dec_monitor,
	output logic                                 dec_rate_counted,
	output logic [LEN_W:0]                       dec_rate_bytes,
	output logic                                 dec_insert_tag,
	output logic [sp2c_pkg::REG_W-1:0]           dec_tag
);
	typedef struct packed {
		logic [sp2c_pkg::REG_W-1:0]  vfm;
		logic [sp2c_pkg::REG_W-1:0]  tag;
		logic [sp2c_pkg::REG_W-1:0]  rate;
		logic [sp2c_pkg::DATA_W-1:0] prdata;
		logic                        pready;
		logic                        pslverr;
		logic                        flow_en;
		logic                        learn_en;
	} sp2c_regs_s;

	sp2c_regs_s s_r;
	sp2c_regs_s s_nxt;
	sp2c_cfg_if cfg ();

	if (LEN_W < 4 || LEN_W > 15) begin : g_chk
		$error("sp2c_regs: LEN_W out of range");
	end

	// one-hot select: bit 0 control, bit 1 default tag, bit 2 rate counting
	function automatic logic [2:0] sp2c_decode(input logic [sp2c_pkg::ADDR_W-1:0] a);
		sp2c_decode = {a == sp2c_pkg::ADDR_RATE, a == sp2c_pkg::ADDR_TAG, a == sp2c_pkg::ADDR_VFM};
	endfunction

	// only lanes 0 and 1 carry register data; masked bits keep their zero
	function automatic logic [15:0] sp2c_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] wmask);
		logic [15:0] lane;
		lane       = {{8{strb[1]}}, {8{strb[0]}}};
		sp2c_merge = ((wd[15:0] & wmask & lane) | (old & ~lane)) & wmask;
	endfunction

	always_comb begin
		logic [2:0] sel;
		logic       wr;
		sel           = sp2c_decode(paddr);
		wr            = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
		s_nxt         = s_r;
		// zero wait state: ready in the first access cycle
		s_nxt.pready  = psel && !penable;
		s_nxt.pslverr = psel && !penable && (sel == 3'b000);
		if (psel && !penable) begin
			s_nxt.prdata = '0;
			if (sel[0]) begin
				s_nxt.prdata[15:0] = s_r.vfm;
			end
			if (sel[1]) begin
				s_nxt.prdata[15:0] = s_r.tag;
			end
			if (sel[2]) begin
				s_nxt.prdata[15:0] = s_r.rate;
			end
		end
		if (wr && sel[0]) begin
			s_nxt.vfm = sp2c_merge(s_r.vfm, pwdata, pstrb, sp2c_pkg::VFM_WMASK);
		end
		if (wr && sel[1]) begin
			s_nxt.tag = sp2c_merge(s_r.tag, pwdata, pstrb, sp2c_pkg::TAG_WMASK);
		end
		if (wr && sel[2]) begin
			s_nxt.rate = sp2c_merge(s_r.rate, pwdata, pstrb, sp2c_pkg::RATE_WMASK);
		end
		// negotiation result is registered here, so the output lags it by one clock
		s_nxt.flow_en = s_r.vfm[sp2c_pkg::B_FFC] || an_flow_ctrl;
		// kept as its own flop so the output needs no inverter behind the register
		s_nxt.learn_en = !s_nxt.vfm[sp2c_pkg::B_LDIS];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r         <= '0;
			s_r.vfm     <= sp2c_pkg::VFM_RST;
			s_r.tag     <= sp2c_pkg::TAG_RST;
			s_r.rate    <= sp2c_pkg::RATE_RST;
			s_r.learn_en <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata          = s_r.prdata;
	assign pready          = s_r.pready;
	assign pslverr         = s_r.pslverr;
	assign flow_ctrl_en    = s_r.flow_en;
	assign backpressure_en = s_r.vfm[sp2c_pkg::B_BPE];
	assign tx_enable       = s_r.vfm[sp2c_pkg::B_TXE];
	assign rx_enable       = s_r.vfm[sp2c_pkg::B_RXE];
	assign learn_enable    = s_r.learn_en;
	assign sniffer_port    = s_r.vfm[sp2c_pkg::B_SNIF];
	assign rx_mirror       = s_r.vfm[sp2c_pkg::B_RXM];
	assign tx_mirror       = s_r.vfm[sp2c_pkg::B_TXM];

	assign cfg.ingress_filter   = s_r.vfm[sp2c_pkg::B_IVF];
	assign cfg.discard_non_pvid = s_r.vfm[sp2c_pkg::B_DNP];
	assign cfg.pri_ceiling      = s_r.vfm[sp2c_pkg::B_UPC];
	assign cfg.rx_en            = s_r.vfm[sp2c_pkg::B_RXE];
	assign cfg.learn_dis        = s_r.vfm[sp2c_pkg::B_LDIS];
	assign cfg.rx_mirror        = s_r.vfm[sp2c_pkg::B_RXM];
	assign cfg.membership       = s_r.vfm[sp2c_pkg::MEMB_W-1:0];
	assign cfg.vlan_identifier              = s_r.tag[sp2c_pkg::VID_W-1:0];
	assign cfg.cfi              = s_r.tag[sp2c_pkg::B_CFI];
	assign cfg.pri              = s_r.tag[sp2c_pkg::PRI_LSB +: sp2c_pkg::PRI_W];
	assign cfg.limit_mode       = s_r.rate[sp2c_pkg::LIM_LSB +: 2];
	assign cfg.count_ifg        = s_r.rate[sp2c_pkg::B_CIFG];
	assign cfg.count_pre        = s_r.rate[sp2c_pkg::B_CPRE];

	sp2c_frame_policy #(
		.LEN_W    (LEN_W),
		.PORT_BIT (sp2c_pkg::P2_BIT)
	) u_policy (
		.clk              (pclk),
		.rst_n            (presetn),
		.cfg              (cfg.policy),
		.tag_insert_en    (egress_tag_insert_en),
		.rx_valid         (rx_valid),
		.rx_tagged        (rx_tagged),
		.rx_vid           (rx_vid),
		.rx_pri           (rx_pri),
		.rx_vlan_members  (rx_vlan_members),
		.rx_dest          (rx_dest),
		.rx_bcast         (rx_bcast),
		.rx_mcast         (rx_mcast),
		.rx_flood_ucast   (rx_flood_ucast),
		.rx_len           (rx_len),
		.dec_valid        (dec_valid),
		.dec_drop         (dec_drop),
		.dec_vid          (dec_vid),
		.dec_pri          (dec_pri),
		.dec_dest         (dec_dest),
		.dec_learn        (dec_learn),
		.dec_monitor      (dec_monitor),
		.dec_rate_counted (dec_rate_counted),
		.dec_rate_bytes   (dec_rate_bytes),
		.dec_insert_tag   (dec_insert_tag),
		.dec_tag          (dec_tag)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_vfm_write;
		psel && penable && pwrite && pready && !pslverr && paddr == sp2c_pkg::ADDR_VFM
			&& pstrb[1] && pstrb[0];
	endsequence

	sequence s_tag_write;
		psel && penable && pwrite && pready && paddr == sp2c_pkg::ADDR_TAG
			&& pstrb[1] && pstrb[0];
	endsequence

	sequence s_rate_write;
		psel && penable && pwrite && pready && paddr == sp2c_pkg::ADDR_RATE
			&& pstrb[1] && pstrb[0];
	endsequence

	// reset values as seen at the first edge after release
	chk_reset_enables: assert property ($rose(presetn)
		|-> tx_enable && rx_enable && learn_enable && !backpressure_en)
		else $error("enable reset values wrong");
	chk_tag_reset: assert property ($rose(presetn)
		|-> cfg.vlan_identifier == 12'h001 && cfg.membership == 3'h7)
		else $error("default tag or membership reset wrong");
	chk_reset_quiet: assert property ($rose(presetn)
		|-> !pready && !pslverr && prdata == '0 && !flow_ctrl_en)
		else $error("bus outputs not idle after reset");
	chk_reset_rate: assert property ($rose(presetn) |-> cfg.limit_mode == 2'b00
		&& !cfg.count_ifg && !cfg.count_pre && !sniffer_port && !rx_mirror && !tx_mirror)
		else $error("rate or mirror reset wrong");

	// zero wait states: exactly one ready pulse per access, none while idle
	chk_pready_setup: assert property (psel && !penable
		|=> pready)
		else $error("no ready in first access cycle");
	chk_ready_pulse: assert property (pready
		|=> !pready)
		else $error("ready held longer than one cycle");
	chk_idle_no_ready: assert property (!psel
		|=> !pready)
		else $error("ready raised without a request");
	chk_unmapped: assert property (psel && !penable && sp2c_decode(paddr) == 3'b000
		|=> pready && pslverr)
		else $error("unmapped access not flagged");
	chk_unmapped_nowrite: assert property (pslverr |=> s_r.vfm == $past(s_r.vfm)
		&& s_r.tag == $past(s_r.tag) && s_r.rate == $past(s_r.rate))
		else $error("unmapped write changed a register");
	chk_read_vfm: assert property (psel && !penable && paddr == sp2c_pkg::ADDR_VFM
		|=> prdata == {16'h0000, $past(s_r.vfm)})
		else $error("control read data wrong");
	chk_read_tag: assert property (psel && !penable && paddr == sp2c_pkg::ADDR_TAG
		|=> prdata == {16'h0000, $past(s_r.tag)})
		else $error("default tag read data wrong");
	chk_reserved_read: assert property (psel && !penable && paddr == sp2c_pkg::ADDR_RATE
		|=> pready && prdata[31:4] == '0)
		else $error("reserved bits read nonzero");

	// register writes land at the access edge and show one clock later; flow_ctrl_en shows two clocks later
	chk_tx_enable_write: assert property (s_vfm_write
		|=> tx_enable == $past(pwdata[10]) && rx_enable == $past(pwdata[9]))
		else $error("enable bits not written");
	chk_force_flow: assert property ((s_vfm_write and pwdata[12])
		|=> ##1 flow_ctrl_en)
		else $error("forced flow control not applied");
	chk_force_hold: assert property (s_r.vfm[sp2c_pkg::B_FFC]
		|=> flow_ctrl_en)
		else $error("flow control off while forced");
	chk_flow_follow: assert property (!s_r.vfm[sp2c_pkg::B_FFC]
		|=> flow_ctrl_en == $past(an_flow_ctrl))
		else $error("flow control ignores negotiation");
	chk_bp_learn: assert property (s_vfm_write
		|=> backpressure_en == $past(pwdata[11]) && learn_enable == !$past(pwdata[8]))
		else $error("backpressure or learning wrong");
	chk_mirror_bits: assert property (s_vfm_write
		|=> {sniffer_port, rx_mirror, tx_mirror} == $past(pwdata[7:5]))
		else $error("mirror bits not written");
	chk_membership_write: assert property (s_vfm_write
		|=> cfg.membership == $past(pwdata[2:0]))
		else $error("membership not written");
	chk_vfm_reserved: assert property (s_vfm_write
		|=> ##1 (s_r.vfm & ~sp2c_pkg::VFM_WMASK) == '0)
		else $error("reserved control bits stored");
	chk_tag_write: assert property (s_tag_write
		|=> {cfg.pri, cfg.cfi, cfg.vlan_identifier} == $past(pwdata[15:0]))
		else $error("default tag not written");
	chk_lane_keep: assert property (psel && penable && pwrite && pready
		&& paddr == sp2c_pkg::ADDR_TAG && !pstrb[1] |=> s_r.tag[15:8] == $past(s_r.tag[15:8]))
		else $error("unstrobed lane written");
	chk_rate_write: assert property (s_rate_write
		|=> {cfg.limit_mode, cfg.count_ifg, cfg.count_pre} == $past(pwdata[3:0]))
		else $error("rate counting bits not written");

	cov_vfm_write: cover property (s_vfm_write);
	cov_tag_read: cover property (psel && !penable && !pwrite && paddr == sp2c_pkg::ADDR_TAG);
	cov_unmapped: cover property (pslverr);
endmodule

// >>> test/tb.sv
// self-checking bench for the port two control register bank
`timescale 1ns/10ps
module tb;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata, q;
	logic        pready, pslverr, e, an_flow_ctrl = 0, egress_tag_insert_en = 0;
	logic        flow_ctrl_en, backpressure_en, tx_enable, rx_enable, learn_enable;
	logic        sniffer_port, rx_mirror, tx_mirror, rx_valid = 0, rx_tagged = 0;
	logic        rx_bcast = 0, rx_mcast = 0, rx_flood_ucast = 0;
	logic [11:0] rx_vid = 12'h000, dec_vid, dec_rate_bytes;
	logic [2:0]  rx_pri = 3'h0, rx_vlan_members = 3'h0, rx_dest = 3'h7, dec_pri, dec_dest;
	logic [10:0] rx_len = 11'h064;
	logic        dec_valid, dec_drop, dec_learn, dec_monitor, dec_rate_counted, dec_insert_tag;
	logic [15:0] dec_tag;
	int          errors = 0;
	int          total_checks = 0;

	sp2c_regs #(.LEN_W(11)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .an_flow_ctrl, .egress_tag_insert_en, .flow_ctrl_en, .backpressure_en,
		.tx_enable, .rx_enable, .learn_enable, .sniffer_port, .rx_mirror, .tx_mirror, .rx_valid,
		.rx_tagged, .rx_vid, .rx_pri, .rx_vlan_members, .rx_dest, .rx_bcast, .rx_mcast,
		.rx_flood_ucast, .rx_len, .dec_valid, .dec_drop, .dec_vid, .dec_pri, .dec_dest,
		.dec_learn, .dec_monitor, .dec_rate_counted, .dec_rate_bytes, .dec_insert_tag, .dec_tag
	);

	always #4 pclk = ~pclk;

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// request held until the rising edge that samples pready; data taken at that edge
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		chk(n < 50, 1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 4'hF);
		chk(q, x);
	endtask

	task automatic frm(input logic tg, input logic [11:0] v, input logic [2:0] p,
		input logic [2:0] m, input logic [2:0] c);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_tagged <= tg;
		rx_vid <= v;
		rx_pri <= p;
		rx_vlan_members <= m;
		{rx_bcast, rx_mcast, rx_flood_ucast} <= c;
		@(posedge pclk);
		rx_valid <= 1'b0;
		#1;
		chk(dec_valid, 1);
	endtask

	task automatic t_reset();
		rdchk(sp2c_pkg::ADDR_VFM, 32'h0000_0607);
		rdchk(sp2c_pkg::ADDR_TAG, 32'h0000_0001);
		rdchk(sp2c_pkg::ADDR_RATE, 32'h0000_0000);
		chk({tx_enable, rx_enable, learn_enable, flow_ctrl_en}, 4'hE);
	endtask

	task automatic t_reserved();
		wr(sp2c_pkg::ADDR_VFM, 32'hFFFF_FFFF);
		rdchk(sp2c_pkg::ADDR_VFM, 32'h0000_7FEF);
		wr(sp2c_pkg::ADDR_TAG, 32'hFFFF_FFFF);
		rdchk(sp2c_pkg::ADDR_TAG, 32'h0000_FFFF);
		wr(sp2c_pkg::ADDR_RATE, 32'hFFFF_FFFF);
		rdchk(sp2c_pkg::ADDR_RATE, 32'h0000_000F);
		apb(1'b1, sp2c_pkg::ADDR_TAG, 32'h0, 4'h1);
		rdchk(sp2c_pkg::ADDR_TAG, 32'h0000_FF00);
		wr(16'h1494, 32'hFFFF_FFFF);
		chk(e, 1);
		rdchk(16'h1494, 32'h0);
		chk(e, 1);
	endtask

	task automatic t_ctrl();
		@(posedge pclk);
		an_flow_ctrl <= 1'b1;
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_0000);
		@(posedge pclk);
		an_flow_ctrl <= 1'b0;
		#1;
		chk({flow_ctrl_en, backpressure_en, tx_enable, rx_enable, learn_enable, sniffer_port,
			rx_mirror, tx_mirror}, 8'h88);
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_19E0);
		@(posedge pclk);
		#1;
		chk({flow_ctrl_en, backpressure_en, tx_enable, rx_enable, learn_enable, sniffer_port,
			rx_mirror, tx_mirror}, 8'hC7);
	endtask

	task automatic t_policy();
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_4607);
		wr(sp2c_pkg::ADDR_TAG, 32'h0000_0005);
		frm(1'b0, 12'h000, 3'h0, 3'b101, 3'b000);
		chk(dec_drop, 1);
		frm(1'b0, 12'h000, 3'h0, 3'b010, 3'b000);
		chk({dec_drop, dec_vid}, {1'b0, 12'h005});
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_2607);
		frm(1'b1, 12'h000, 3'h0, 3'b000, 3'b000);
		chk({dec_drop, dec_vid}, {1'b0, 12'h005});
		frm(1'b1, 12'h007, 3'h6, 3'b000, 3'b000);
		chk({dec_drop, dec_vid, dec_pri}, {1'b1, 12'h007, 3'h6});
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_064B);
		wr(sp2c_pkg::ADDR_TAG, 32'h0000_5005);
		frm(1'b1, 12'h007, 3'h6, 3'b000, 3'b000);
		chk({dec_drop, dec_pri, dec_dest, dec_learn, dec_monitor}, 9'h04F);
		frm(1'b1, 12'h007, 3'h1, 3'b000, 3'b000);
		chk(dec_pri, 3'h1);
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_0707);
		frm(1'b1, 12'h007, 3'h1, 3'b000, 3'b000);
		chk({dec_drop, dec_learn}, 2'b00);
		wr(sp2c_pkg::ADDR_VFM, 32'h0000_0407);
		frm(1'b1, 12'h007, 3'h1, 3'b000, 3'b000);
		chk(dec_drop, 1);
	endtask

	task automatic t_rate();
		int b;
		for (int i = 0; i < 4; i++) begin
			b = 100 + (i[1] ? 12 : 0) + (i[0] ? 8 : 0);
			wr(sp2c_pkg::ADDR_RATE, {28'h0, i[1:0], i[1:0]});
			frm(1'b0, 12'h000, 3'h0, 3'b000, 3'b001);
			chk({dec_rate_counted, dec_rate_bytes}, {i < 2, b[11:0]});
			frm(1'b0, 12'h000, 3'h0, 3'b000, 3'b010);
			chk(dec_rate_counted, i < 3);
			frm(1'b0, 12'h000, 3'h0, 3'b000, 3'b100);
			chk(dec_rate_counted, 1);
			frm(1'b0, 12'h000, 3'h0, 3'b000, 3'b000);
			chk(dec_rate_counted, i == 0);
		end
		@(posedge pclk);
		egress_tag_insert_en <= 1'b1;
		frm(1'b0, 12'h000, 3'h0, 3'b000, 3'b000);
		chk({dec_insert_tag, dec_tag}, {1'b1, 16'h5005});
		frm(1'b1, 12'h009, 3'h0, 3'b000, 3'b000);
		chk(dec_insert_tag, 0);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_reserved();
		t_ctrl();
		t_policy();
		t_rate();
		test_done();
	end

	// whole run needs about a hundred and fifty cycles
	initial begin
		#100000;
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
endmodule
